/* File: logic/cssr_ctl_if.sv */
`timescale 1ns/1ps

interface cssr_ctl_if;
    logic hold;
    logic word_due;
    logic settled;

    modport ctrl (
        output hold,
        input word_due,
        input settled
    );

    modport timer (
        input hold,
        output word_due,
        output settled
    );
endinterface

/* File: logic/cssr_params.svh */
`ifndef CSSR_PARAMS_SVH
`define CSSR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
// Output-rate periods the filter needs to settle after a restart.
`define CSSR_SETTLE_PERIODS 2'd3
// Length of the high excursion of the ready flag, in master clock periods.
`define CSSR_UPD_HIGH_CYC 10'd500
// Default length of one output-rate period, in master clock periods.
`define CSSR_OUT_PERIOD_DEF 1000

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CSSR_DATA_RESET 24'h000000
`define CSSR_READY_N_RESET 1'b1
`define CSSR_PIN_IDLE 1'b1
`define CSSR_BIT_IDLE 1'b0

// ----------------------------------------------------------------------------
// Field positions of the synchronised control vector
// ----------------------------------------------------------------------------
`define CSSR_CTL_RESTART_N 0
`define CSSR_CTL_RESTART_BIT 1
`define CSSR_CTL_RESET_N 2
`define CSSR_CTL_STANDBY_N 3
`define CSSR_CTL_WIDTH 4

`endif

/* File: logic/cssr_pkg.sv */
package cssr_pkg;

    // ------------------------------------------------------------------------
    // Ready flag sequencing
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        CSSR_RDY_IDLE = 4'b0001,
        CSSR_RDY_UPD = 4'b0010,
        CSSR_RDY_HIGH = 4'b0100,
        CSSR_RDY_LOW = 4'b1000
    } cssr_rdy_t;

    // ------------------------------------------------------------------------
    // Operating condition of the converter core
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        CSSR_OP_RUN = 4'b0001,
        CSSR_OP_RESTART = 4'b0010,
        CSSR_OP_STANDBY = 4'b0100,
        CSSR_OP_RESET = 4'b1000
    } cssr_op_t;

endpackage

/* File: logic/cssr_rate.sv */
`timescale 1ns/1ps
`include "cssr_params.svh"

module cssr_rate #(
    parameter int PERIOD_CYC = `CSSR_OUT_PERIOD_DEF,
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    cssr_ctl_if.timer ctl
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [1:0] settle;
        logic word_due;
    } cssr_rate_st_t;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_CYC - 1);

    cssr_rate_st_t st;
    cssr_rate_st_t next_st;

    // ------------------------------------------------------------------------
    // Output-rate timer with filter settling count
    // ------------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.word_due = 1'b0;
        if (!rst_n || ctl.hold) begin
            // Filter and modulator sit in their known state.
            next_st.cnt = '0;
            next_st.settle = 2'd0;
        end else if (st.cnt == LAST) begin
            next_st.cnt = '0;
            if (st.settle >= `CSSR_SETTLE_PERIODS - 2'd1) begin
                next_st.word_due = 1'b1;
                next_st.settle = `CSSR_SETTLE_PERIODS;
            end else begin
                next_st.settle = st.settle + 2'd1;
            end
        end else begin
            // Counting starts on the first edge after release.
            next_st.cnt = st.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign ctl.word_due = st.word_due;
    assign ctl.settled = (st.settle == `CSSR_SETTLE_PERIODS);
endmodule

/* File: logic/cssr_sync.sv */
`timescale 1ns/1ps
`include "cssr_params.svh"

module cssr_sync #(
    parameter int WIDTH = `CSSR_CTL_WIDTH,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } cssr_sync_st_t;

    cssr_sync_st_t st;
    cssr_sync_st_t next_st;

    // ------------------------------------------------------------------------
    // Two-stage synchroniser, one lane per control input
    // ------------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
        if (!rst_n) begin
            next_st.stage1 = INIT;
            next_st.stage2 = INIT;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign sync_out = st.stage2;
endmodule

/* File: logic/cssr_top.sv */
// Summary of operation
// - Restart by low pin or set bit clears filter and modulator, keeps setup.
// - Pin falling edge or bit set forces filter and modulator to a known state.
// - Known state holds while the pin stays low or the bit stays set.
// - Pin rise or bit clear releases the filter; sampling starts next edge.
// - Devices on a common clock and restart update within one clock cycle.
// - Start-convert: pin rise starts conversion, ready flag low marks completion.
// - Start-convert results include full settling, one third of free-run rate.
// - No output word is loaded until three output periods after any restart.
// - A restart never raises a low ready flag; unread word remains.
// - Update while flag low raises it for 500 clocks, then low again.
// - Read after restart raises the flag until settled with a new word.
// - Flag high after a read at restart stays high until settling; an update high still falls after 500 clocks.
// - Reset pin low clears logic, filter, modulator and all registers.
// - While reset pin is low the flag is high and accesses are ignored.
// - After reset release a valid word and low flag come three periods later.
// - Oscillator keeps running during reset; clock output uninterrupted.
// - Standby keeps every register, the data register included.
// - Entering standby resets the serial interface and drives the flag high.
// - No data can be read while in standby.
// - Leaving standby gives a new word three output periods later.
// - Oscillator keeps running in standby; clock output stays available.
// - Flag rises just before the output register updates.
`timescale 1ns/1ps
`include "cssr_params.svh"

module cssr_top #(
    parameter int DATA_W = 24,
    parameter int PERIOD_CYC = `CSSR_OUT_PERIOD_DEF,
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic restart_n,
    input wire logic filter_restart_bit,
    input wire logic reset_n,
    input wire logic standby_n,
    input wire logic data_read,
    input wire logic [DATA_W-1:0] filter_data,
    output logic result_ready_n,
    output logic [DATA_W-1:0] data_out,
    output logic data_load,
    output logic filter_hold,
    output logic iface_reset,
    output logic read_ignored,
    output logic settling,
    output logic mclk_out_en,
    output cssr_pkg::cssr_op_t op_state
);
    import cssr_pkg::*;

    // ------------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------------
    typedef struct packed {
        cssr_rdy_t rdy;
        cssr_op_t op;
        logic ready_n;
        logic [DATA_W-1:0] data;
        logic [9:0] high_cnt;
        logic was_low;
        logic data_load;
        logic filter_hold;
        logic iface_reset;
        logic read_ignored;
        logic settling;
        logic osc_run;
    } cssr_top_st_t;

    cssr_top_st_t st;
    cssr_top_st_t next_st;

    logic [`CSSR_CTL_WIDTH-1:0] ctl_raw;
    logic [`CSSR_CTL_WIDTH-1:0] ctl_sync;
    logic restart_req;
    logic pin_reset;
    logic pin_standby;

    cssr_ctl_if ctl ();

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    always_comb begin
        ctl_raw = '0;
        ctl_raw[`CSSR_CTL_RESTART_N] = restart_n;
        ctl_raw[`CSSR_CTL_RESTART_BIT] = filter_restart_bit;
        ctl_raw[`CSSR_CTL_RESET_N] = reset_n;
        ctl_raw[`CSSR_CTL_STANDBY_N] = standby_n;
    end

    cssr_sync #(
        .WIDTH(`CSSR_CTL_WIDTH),
        .INIT({`CSSR_PIN_IDLE, `CSSR_PIN_IDLE, `CSSR_BIT_IDLE, `CSSR_PIN_IDLE})
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(ctl_raw),
        .sync_out(ctl_sync)
    );

    // Restart is a level: either source keeps the filter held.
    assign restart_req = !ctl_sync[`CSSR_CTL_RESTART_N] || ctl_sync[`CSSR_CTL_RESTART_BIT];
    assign pin_reset = !ctl_sync[`CSSR_CTL_RESET_N];
    assign pin_standby = !ctl_sync[`CSSR_CTL_STANDBY_N];

    // ------------------------------------------------------------------------
    // Output-rate timer
    // ------------------------------------------------------------------------
    assign ctl.hold = st.filter_hold;

    cssr_rate #(
        .PERIOD_CYC(PERIOD_CYC),
        .CNT_W(CNT_W)
    ) u_rate (
        .mclk(mclk),
        .rst_n(rst_n),
        .ctl(ctl.timer)
    );

    // ------------------------------------------------------------------------
    // Helper decoding
    // ------------------------------------------------------------------------
    function automatic cssr_op_t op_decode(input logic rst_pin, input logic stby,
                                           input logic restart);
        cssr_op_t op;
        op = CSSR_OP_RUN;
        if (rst_pin) begin
            op = CSSR_OP_RESET;
        end else if (stby) begin
            op = CSSR_OP_STANDBY;
        end else if (restart) begin
            op = CSSR_OP_RESTART;
        end
        return op;
    endfunction

    // ------------------------------------------------------------------------
    // Control and ready flag sequencing
    // ------------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.data_load = 1'b0;
        next_st.read_ignored = 1'b0;
        next_st.osc_run = 1'b1;
        next_st.op = op_decode(pin_reset, pin_standby, restart_req);
        // Filter and modulator reset; setup state is untouched.
        next_st.filter_hold = pin_reset || pin_standby || restart_req;
        next_st.iface_reset = pin_reset || pin_standby;
        next_st.settling = next_st.filter_hold || !ctl.settled;

        if (!rst_n) begin
            next_st.rdy = CSSR_RDY_IDLE;
            next_st.op = CSSR_OP_RESET;
            next_st.ready_n = `CSSR_READY_N_RESET;
            next_st.data = DATA_W'(`CSSR_DATA_RESET);
            next_st.high_cnt = 10'd0;
            next_st.was_low = 1'b0;
            next_st.filter_hold = 1'b1;
            next_st.iface_reset = 1'b1;
            next_st.settling = 1'b1;
        end else if (pin_reset) begin
            // Everything returns to defaults; accesses are dropped.
            next_st.rdy = CSSR_RDY_IDLE;
            next_st.ready_n = 1'b1;
            next_st.data = DATA_W'(`CSSR_DATA_RESET);
            next_st.high_cnt = 10'd0;
            next_st.was_low = 1'b0;
            next_st.read_ignored = data_read;
        end else if (pin_standby) begin
            // Data register keeps its contents; only the flag is forced.
            next_st.rdy = CSSR_RDY_IDLE;
            next_st.ready_n = 1'b1;
            next_st.high_cnt = 10'd0;
            next_st.was_low = 1'b0;
            next_st.read_ignored = data_read;
        end else begin
            // A restart leaves the flag as it is; only the timer is held.
            case (st.rdy)
                CSSR_RDY_IDLE: begin
                    next_st.ready_n = 1'b1;
                    if (ctl.word_due) begin
                        next_st.rdy = CSSR_RDY_UPD;
                        next_st.was_low = 1'b0;
                    end
                end
                CSSR_RDY_LOW: begin
                    next_st.ready_n = 1'b0;
                    if (ctl.word_due) begin
                        // Flag rises a cycle ahead of the register update.
                        next_st.rdy = CSSR_RDY_UPD;
                        next_st.ready_n = 1'b1;
                        next_st.was_low = 1'b1;
                    end else if (data_read) begin
                        next_st.rdy = CSSR_RDY_IDLE;
                        next_st.ready_n = 1'b1;
                    end
                end
                CSSR_RDY_UPD: begin
                    // Register loads while the flag is high.
                    next_st.data = filter_data;
                    next_st.data_load = 1'b1;
                    next_st.read_ignored = data_read;
                    next_st.high_cnt = 10'd0;
                    if (st.was_low) begin
                        next_st.rdy = CSSR_RDY_HIGH;
                        next_st.ready_n = 1'b1;
                    end else begin
                        // Completion of a conversion shows as the falling flag.
                        next_st.rdy = CSSR_RDY_LOW;
                        next_st.ready_n = 1'b0;
                    end
                end
                CSSR_RDY_HIGH: begin
                    next_st.ready_n = 1'b1;
                    next_st.high_cnt = st.high_cnt + 10'd1;
                    if (ctl.word_due) begin
                        next_st.rdy = CSSR_RDY_UPD;
                        next_st.was_low = 1'b1;
                    end else if (data_read) begin
                        next_st.rdy = CSSR_RDY_IDLE;
                    end else if (st.high_cnt == `CSSR_UPD_HIGH_CYC - 10'd2) begin
                        // Update cycle plus this wait make the full high time.
                        next_st.rdy = CSSR_RDY_LOW;
                        next_st.ready_n = 1'b0;
                    end
                end
                default: begin
                    next_st.rdy = CSSR_RDY_IDLE;
                    next_st.ready_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign result_ready_n = st.ready_n;
    assign data_out = st.data;
    assign data_load = st.data_load;
    assign filter_hold = st.filter_hold;
    assign iface_reset = st.iface_reset;
    assign read_ignored = st.read_ignored;
    assign settling = st.settling;
    assign mclk_out_en = st.osc_run;
    assign op_state = st.op;
endmodule

/* File: testbench/cssr_chk.sv */
`timescale 1ns/1ps

module cssr_chk #(
    parameter int DATA_W = 24,
    parameter int PERIOD_CYC = 1000
) (
    input logic mclk,
    input logic rst_n,
    input logic restart_n,
    input logic filter_restart_bit,
    input logic reset_n,
    input logic standby_n,
    input logic data_read,
    input logic [DATA_W-1:0] filter_data,
    input logic result_ready_n,
    input logic [DATA_W-1:0] data_out,
    input logic data_load,
    input logic filter_hold,
    input logic iface_reset,
    input logic read_ignored,
    input logic settling,
    input logic mclk_out_en,
    input cssr_pkg::cssr_op_t op_state
);
    import cssr_pkg::*;
    int run_cnt;
    int hi_cnt;
    logic pend;

    // Cycles since the filter was last held, length of the current flag high, and
    // whether that high began one cycle before a load.
    always_ff @(posedge mclk) begin
        run_cnt <= (!rst_n || filter_hold || iface_reset || !reset_n || !standby_n) ? 0
                   : run_cnt + 1;
        hi_cnt <= (!rst_n || !result_ready_n) ? 0 : hi_cnt + 1;
        pend <= (!rst_n || !result_ready_n) ? 1'b0 : (pend || (data_load && hi_cnt == 1));
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence held_s;
        (!restart_n && reset_n && standby_n) [*5];
    endsequence
    sequence run_s;
        restart_n && !filter_restart_bit && reset_n && standby_n;
    endsequence

    hold_on_fall_a: assert property ($fell(restart_n) |-> ##[3:4] filter_hold)
        else $error("restart fall did not hold filter");
    hold_low_a: assert property (held_s |-> filter_hold)
        else $error("filter released while restart low");
    release_a: assert property ($rose(restart_n) ##0 run_s ##1 run_s [*3] |=> !filter_hold)
        else $error("filter not released");
    early_load_a: assert property (data_load |-> run_cnt >= 3 * PERIOD_CYC - 2)
        else $error("word loaded before settling");
    settle_flag_a: assert property (filter_hold |-> settling)
        else $error("settling low while filter held");
    load_word_a: assert property (data_load |-> data_out == $past(filter_data))
        else $error("data register missed filter word");
    flag_before_a: assert property (data_load |-> $past(result_ready_n))
        else $error("flag low across update");
    flag_fall_a: assert property (data_load && hi_cnt != 1 |-> !result_ready_n)
        else $error("flag not low with new word");
    pulse_end_a: assert property ($fell(result_ready_n) && pend |-> hi_cnt == 500)
        else $error("flag high span wrong");
    restart_keep_a: assert property (held_s ##0 (!result_ready_n && !data_read)
        |=> !result_ready_n)
        else $error("restart raised a low flag");
    read_raise_a: assert property (data_read && !data_load && reset_n && standby_n
        |=> result_ready_n)
        else $error("read did not raise flag");
    standby_a: assert property ((!standby_n && reset_n) [*5] |-> result_ready_n && iface_reset)
        else $error("standby flag or interface reset wrong");
    reset_a: assert property (!reset_n [*5] |-> result_ready_n && data_out == '0
        && op_state == CSSR_OP_RESET)
        else $error("reset pin state wrong");
    clock_a: assert property (mclk_out_en)
        else $error("clock output stopped");
endmodule

bind cssr_top cssr_chk #(.DATA_W(DATA_W), .PERIOD_CYC(PERIOD_CYC)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .restart_n(restart_n), .filter_restart_bit(filter_restart_bit),
    .reset_n(reset_n), .standby_n(standby_n), .data_read(data_read), .filter_data(filter_data),
    .result_ready_n(result_ready_n), .data_out(data_out), .data_load(data_load),
    .filter_hold(filter_hold), .iface_reset(iface_reset), .read_ignored(read_ignored),
    .settling(settling), .mclk_out_en(mclk_out_en), .op_state(op_state)
);

/* File: testbench/cssr_host_model.sv */
`timescale 1ns/1ps

module cssr_host_model #(
    parameter int DATA_W = 24
) (
    input logic mclk,
    input logic rst_n,
    input logic data_load,
    output logic [DATA_W-1:0] filter_data
);
    // The filter offers a fresh word after every load, so a stale capture never matches.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            filter_data <= DATA_W'(24'h5a0013);
        end else if (data_load) begin
            filter_data <= ~filter_data + DATA_W'(24'h010203);
        end
    end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    import cssr_pkg::*;
    localparam int P = 600;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic restart_n = 1'b1;
    logic filter_restart_bit = 1'b0;
    logic reset_n = 1'b1;
    logic standby_n = 1'b1;
    logic data_read = 1'b0;
    logic [23:0] filter_data;
    logic [23:0] data_out;
    logic result_ready_n, data_load, filter_hold, iface_reset, read_ignored, mclk_out_en;
    logic settling;
    cssr_op_t op_state;
    int mismatches = 0;
    int checks = 0;

    always #2 mclk = ~mclk;

    cssr_top #(.PERIOD_CYC(P)) dut (
        .mclk(mclk), .rst_n(rst_n), .restart_n(restart_n),
        .filter_restart_bit(filter_restart_bit), .reset_n(reset_n), .standby_n(standby_n),
        .data_read(data_read), .filter_data(filter_data), .result_ready_n(result_ready_n),
        .data_out(data_out), .data_load(data_load), .filter_hold(filter_hold),
        .iface_reset(iface_reset), .read_ignored(read_ignored), .settling(settling),
        .mclk_out_en(mclk_out_en), .op_state(op_state)
    );
    cssr_host_model host (.mclk(mclk), .rst_n(rst_n), .data_load(data_load),
        .filter_data(filter_data));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic pulse_read();
        data_read = 1'b1;
        tick(1);
        data_read = 1'b0;
    endtask

    // Waits for the next word; n counts cycles, lo notes a low flag before it.
    task automatic wait_load(output int n, output logic lo);
        logic [23:0] w;
        n = 0;
        lo = 1'b0;
        do begin
            w = filter_data;
            lo = lo | (result_ready_n !== 1'b1);
            tick(1);
            n++;
        end while (data_load !== 1'b1 && n < 5 * P);
        chk("word", w, data_out);
    endtask

    task automatic span(output int n);
        n = 0;
        while (result_ready_n === 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_startup();
        int n;
        logic lo;
        wait_load(n, lo);
        chk("settle", 1, n >= 3 * P && n <= 3 * P + 10);
        chk("flag", 0, result_ready_n);
        chk("settling", 0, settling);
        chk("op run", 1, op_state === CSSR_OP_RUN);
    endtask

    task automatic t_pulse();
        int n;
        logic lo;
        wait_load(n, lo);
        chk("period", P, n);
        chk("flag", 1, result_ready_n);
        span(n);
        chk("high span", 499, n);
    endtask

    task automatic t_read();
        int n;
        logic lo;
        pulse_read();
        chk("flag", 1, result_ready_n);
        wait_load(n, lo);
        chk("low early", 0, lo);
        chk("flag", 0, result_ready_n);
    endtask

    task automatic t_sync_pin();
        int n;
        logic lo;
        logic [23:0] held;
        held = data_out;
        restart_n = 1'b0;
        tick(4);
        chk("hold", 1, filter_hold);
        chk("op restart", 1, op_state === CSSR_OP_RESTART);
        tick(10);
        chk("hold", 1, filter_hold);
        chk("settling", 1, settling);
        chk("flag", 0, result_ready_n);
        chk("kept", held, data_out);
        restart_n = 1'b1;
        wait_load(n, lo);
        chk("settle", 1, n >= 3 * P && n <= 3 * P + 10);
        // A fixed latency from the pin edge keeps devices on one clock in step.
        chk("lockstep", 3 * P + 5, n);
        chk("flag", 1, result_ready_n);
        span(n);
        chk("high span", 499, n);
    endtask

    task automatic t_sync_bit();
        int n;
        logic lo;
        pulse_read();
        filter_restart_bit = 1'b1;
        tick(4);
        chk("hold", 1, filter_hold);
        tick(6);
        filter_restart_bit = 1'b0;
        wait_load(n, lo);
        chk("settle", 1, n >= 3 * P && n <= 3 * P + 10);
        chk("low early", 0, lo);
        chk("flag", 0, result_ready_n);
    endtask

    task automatic t_standby();
        int n;
        logic lo;
        logic [23:0] held;
        held = data_out;
        standby_n = 1'b0;
        tick(4);
        chk("flag", 1, result_ready_n);
        chk("iface reset", 1, iface_reset);
        chk("op standby", 1, op_state === CSSR_OP_STANDBY);
        pulse_read();
        chk("refused", 1, read_ignored);
        chk("kept", held, data_out);
        chk("clock out", 1, mclk_out_en);
        tick(10);
        standby_n = 1'b1;
        wait_load(n, lo);
        chk("settle", 1, n >= 3 * P && n <= 3 * P + 10);
    endtask

    task automatic t_reset_pin();
        int n;
        logic lo;
        reset_n = 1'b0;
        tick(4);
        chk("flag", 1, result_ready_n);
        chk("cleared", 0, data_out);
        chk("op reset", 1, op_state === CSSR_OP_RESET);
        pulse_read();
        chk("refused", 1, read_ignored);
        chk("clock out", 1, mclk_out_en);
        tick(10);
        // The host runs on default setup afterwards; no setup registers exist here.
        reset_n = 1'b1;
        wait_load(n, lo);
        chk("settle", 1, n >= 3 * P && n <= 3 * P + 10);
        chk("flag", 0, result_ready_n);
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        tick(12);
        rst_n = 1'b1;
        t_startup();
        t_pulse();
        t_read();
        t_sync_pin();
        t_sync_bit();
        t_standby();
        t_reset_pin();
        give_verdict();
    end

    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule
